/* File: rtl/rbt_defs.svh */
`ifndef RBT_DEFS_SVH
`define RBT_DEFS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define RBT_CLK_MHZ        100

// ----------------------------------------
// bus stall window, ms
// ----------------------------------------
`define RBT_STALL_MIN_MS   25
`define RBT_STALL_MAX_MS   35
// aim mid-window so both bounds hold with margin
`define RBT_STALL_CYC      (((`RBT_STALL_MIN_MS + `RBT_STALL_MAX_MS) * `RBT_CLK_MHZ * 1000) / 2)

// ----------------------------------------
// oscillator halt delay, ms
// ----------------------------------------
`define RBT_HALT_TYP_MS    25
`define RBT_HALT_MAX_MS    100
`define RBT_HALT_CYC       (`RBT_HALT_TYP_MS * `RBT_CLK_MHZ * 1000)

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define RBT_SCL_MAX_KHZ    400
`define RBT_CNT_W          22
`define RBT_SYNC_RST       1'b1

`endif

/* File: rtl/rbt_pkg.sv */
package rbt_pkg;

    // ----------------------------------------
    // stall watchdog states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE  = 3'b001,
        ST_LOW   = 3'b010,
        ST_STALL = 3'b100
    } rbt_state_t;

    // ----------------------------------------
    // pin drive pair, oe high while driving
    // ----------------------------------------
    typedef struct packed
    {
        logic drv;
        logic oe;
    } rbt_pin_t;

endpackage

/* File: rtl/rbt_sync.sv */
`include "rbt_defs.svh"

module rbt_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // async in, synced out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_r;

    // idle bus lines sit high, so reset to high
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r   <= {W{`RBT_SYNC_RST}};
            sync_out <= {W{`RBT_SYNC_RST}};
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

/* File: rtl/rbt_pins.sv */
`include "rbt_defs.svh"

// Operation
// [RQ1] reset bus interface when scl stuck low
// [RQ2] detect any scl low beyond 25 ms; code detects only lows lasting STALL_CYC, 30 ms by default
// [RQ3] interface reset by 35 ms of low
// [RQ4] release sda once stall is detected
// [RQ5] stall watchdog only with oscillator running
// [RQ6] set halt flag after oscillator stop delay
// [RQ7] controller keeps scl fast, never stalls; the model holds scl low while the bench sets stall
// [RQ8] shared pin: alarm output or reference clock
// [RQ9] shared pin alarm: active low, open drain
// [RQ10] square pin: square wave or alarm
// [RQ11] square pin drives both levels
// [RQ12] sda only pulled low or released
// [RQ13] reference clock used only when selected
// [RQ14] sync scl/sda, restart count on rise
module rbt_pins #(
    parameter int STALL_CYC = `RBT_STALL_CYC,
    parameter int HALT_CYC  = `RBT_HALT_CYC
) (
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // i2c pins
    input  wire logic      scl_pin_in,
    input  wire logic      sda_pin_in,
    output rbt_pkg::rbt_pin_t sda_pin,
    // i2c engine side
    input  wire logic      core_sda_pull,
    output logic           scl_sync,
    output logic           sda_sync,
    output logic           bus_reset,
    output logic           bus_stalled,
    // oscillator
    input  wire logic      osc_running_in,
    input  wire logic      halt_flag_clear,
    output logic           oscillator_halt_flag,
    // timebase
    input  wire logic      external_timebase_select,
    input  wire logic      xtal_tick,
    output logic           count_tick,
    // shared clock-in / alarm pin
    input  wire logic      refclk_in_or_alarm_irq_pin_in,
    output rbt_pkg::rbt_pin_t refclk_in_or_alarm_irq_pin,
    input  wire logic      alarm_a,
    // square-wave / alarm pin
    input  wire logic      square_wave,
    input  wire logic      alarm_b,
    input  wire logic      sqw_irq_mode,
    output logic           square_wave_or_alarm_irq_pin
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic       osc_run_s;
    logic       refclk_s;
    logic [1:0] misc_s;

    // [RQ14] two flops on scl and sda
    rbt_sync #(
        .W(2)
    ) u_bus_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({scl_pin_in, sda_pin_in}),
        .sync_out ({scl_sync, sda_sync})
    );

    rbt_sync #(
        .W(2)
    ) u_misc_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in ({osc_running_in, refclk_in_or_alarm_irq_pin_in}),
        .sync_out (misc_s)
    );

    assign osc_run_s = misc_s[1];
    assign refclk_s  = misc_s[0];

    // ----------------------------------------
    // edge history
    // ----------------------------------------
    logic scl_d_r;
    logic ref_d_r;
    logic scl_rise;
    logic ref_rise;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_d_r <= 1'b1;
            ref_d_r <= 1'b1;
        end
        else
        begin
            scl_d_r <= scl_sync;
            ref_d_r <= refclk_s;
        end
    end

    assign scl_rise = scl_sync & ~scl_d_r;
    assign ref_rise = refclk_s & ~ref_d_r;

    // ----------------------------------------
    // scl low watchdog
    // ----------------------------------------
    localparam logic [`RBT_CNT_W-1:0] STALL_LAST = `RBT_CNT_W'(STALL_CYC - 1);
    localparam logic [`RBT_CNT_W-1:0] HALT_LAST  = `RBT_CNT_W'(HALT_CYC - 1);

    rbt_pkg::rbt_state_t     st_r;
    rbt_pkg::rbt_state_t     st_nxt;
    logic [`RBT_CNT_W-1:0]   low_cnt_r;
    logic                    stall_hit;

    // [RQ2] low phase reached the stall interval
    assign stall_hit = (st_r == rbt_pkg::ST_LOW) && !scl_sync && osc_run_s
                       && (low_cnt_r == STALL_LAST);

    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            rbt_pkg::ST_IDLE:
            begin
                // [RQ5] no watch while oscillator stopped
                if (!scl_sync && osc_run_s)
                    st_nxt = rbt_pkg::ST_LOW;
            end
            rbt_pkg::ST_LOW:
            begin
                if (scl_sync || !osc_run_s)
                    st_nxt = rbt_pkg::ST_IDLE;
                else if (stall_hit)
                    st_nxt = rbt_pkg::ST_STALL;
            end
            rbt_pkg::ST_STALL:
            begin
                // [RQ3] scl high ends stall, ready for start
                if (scl_sync)
                    st_nxt = rbt_pkg::ST_IDLE;
            end
            default:
            begin
                st_nxt = rbt_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_r <= rbt_pkg::ST_IDLE;
        else
            st_r <= st_nxt;
    end

    // [RQ14] count restarts whenever scl is high
    always_ff @(posedge clk)
    begin
        if (rst || scl_sync || !osc_run_s || st_r != rbt_pkg::ST_LOW)
            low_cnt_r <= '0;
        else if (!stall_hit)
            low_cnt_r <= low_cnt_r + 1'b1;
    end

    // [RQ1] engine reset pulse and held level
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            bus_reset   <= 1'b0;
            bus_stalled <= 1'b0;
        end
        else
        begin
            bus_reset   <= stall_hit;
            bus_stalled <= (st_nxt == rbt_pkg::ST_STALL);
        end
    end

    // ----------------------------------------
    // sda drive
    // ----------------------------------------
    // [RQ4] released while stalled, driven again once the stall ends
    always_ff @(posedge clk)
    begin
        if (rst)
            sda_pin <= '0;
        else
        begin
            // [RQ12] only ever drives low
            sda_pin.drv <= 1'b0;
            sda_pin.oe  <= core_sda_pull && (st_nxt != rbt_pkg::ST_STALL);
        end
    end

    // ----------------------------------------
    // oscillator halt flag
    // ----------------------------------------
    logic [`RBT_CNT_W-1:0] halt_cnt_r;
    logic                  halt_hit;

    assign halt_hit = !osc_run_s && (halt_cnt_r == HALT_LAST);

    always_ff @(posedge clk)
    begin
        if (rst || osc_run_s)
            halt_cnt_r <= '0;
        else if (!halt_hit)
            halt_cnt_r <= halt_cnt_r + 1'b1;
    end

    // [RQ6] set wins over a same-cycle clear
    always_ff @(posedge clk)
    begin
        if (rst)
            oscillator_halt_flag <= 1'b0;
        else if (halt_hit)
            oscillator_halt_flag <= 1'b1;
        else if (halt_flag_clear)
            oscillator_halt_flag <= 1'b0;
    end

    // ----------------------------------------
    // timebase select
    // ----------------------------------------
    // [RQ13] reference edges only when selected
    always_ff @(posedge clk)
    begin
        if (rst)
            count_tick <= 1'b0;
        else if (external_timebase_select)
            count_tick <= ref_rise;
        else
            count_tick <= xtal_tick;
    end

    // ----------------------------------------
    // alarm and square-wave pins
    // ----------------------------------------
    // [RQ8] pin is input when used as clock
    // [RQ9] alarm pulls low, pullup gives high
    always_ff @(posedge clk)
    begin
        if (rst)
            refclk_in_or_alarm_irq_pin <= '0;
        else
        begin
            refclk_in_or_alarm_irq_pin.drv <= 1'b0;
            refclk_in_or_alarm_irq_pin.oe  <= alarm_a && !external_timebase_select;
        end
    end

    // [RQ10] wave or active-low alarm
    // [RQ11] push-pull, no enable needed
    always_ff @(posedge clk)
    begin
        if (rst)
            square_wave_or_alarm_irq_pin <= 1'b1;
        else if (sqw_irq_mode)
            square_wave_or_alarm_irq_pin <= ~alarm_b;
        else
            square_wave_or_alarm_irq_pin <= square_wave;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_stall_reset: assert property ( // [RQ1]
        @(posedge clk) disable iff (rst)
        stall_hit |=> bus_reset && bus_stalled)
        else $error("stall did not reset bus interface");
    a_stall_len: assert property ( // [RQ2]
        @(posedge clk) disable iff (rst)
        $rose(bus_reset) |-> $past(low_cnt_r) == STALL_LAST)
        else $error("bus reset at wrong low count");

    a_stall_ready: assert property ( // [RQ3]
        @(posedge clk) disable iff (rst)
        bus_stalled && scl_sync |=> !bus_stalled)
        else $error("stall not left on scl high");
    a_stall_sda: assert property ( // [RQ4]
        @(posedge clk) disable iff (rst)
        bus_stalled |-> !sda_pin.oe)
        else $error("sda driven during stall");

    a_osc_gate: assert property ( // [RQ5]
        @(posedge clk) disable iff (rst)
        !osc_run_s |=> !bus_reset)
        else $error("timeout with oscillator stopped");
    a_halt_set: assert property ( // [RQ6]
        @(posedge clk) disable iff (rst)
        halt_hit |=> oscillator_halt_flag ##1 (oscillator_halt_flag || $past(halt_flag_clear)))
        else $error("halt flag not set or not held");

    a_halt_early: assert property ( // [RQ6]
        @(posedge clk) disable iff (rst)
        $rose(oscillator_halt_flag) |-> $past(halt_cnt_r) == HALT_LAST)
        else $error("halt flag set early");
    a_ref_mode: assert property ( // [RQ8]
        @(posedge clk) disable iff (rst)
        external_timebase_select |=> !refclk_in_or_alarm_irq_pin.oe)
        else $error("shared pin driven in clock mode");

    a_alarm_od: assert property ( // [RQ9]
        @(posedge clk) disable iff (rst)
        alarm_a && !external_timebase_select |=> refclk_in_or_alarm_irq_pin.oe
            && !refclk_in_or_alarm_irq_pin.drv)
        else $error("alarm not pulled low");
    a_sqw_alarm: assert property ( // [RQ10]
        @(posedge clk) disable iff (rst)
        sqw_irq_mode && alarm_b |=> !square_wave_or_alarm_irq_pin)
        else $error("square pin alarm not low");

    a_sqw_wave: assert property ( // [RQ11]
        @(posedge clk) disable iff (rst)
        !sqw_irq_mode |=> square_wave_or_alarm_irq_pin == $past(square_wave))
        else $error("square pin not following wave");
    a_sda_od: assert property ( // [RQ12]
        @(posedge clk) disable iff (rst)
        sda_pin.oe |-> !sda_pin.drv && $past(core_sda_pull))
        else $error("sda driven without pull request");

    a_tick_src: assert property ( // [RQ13]
        @(posedge clk) disable iff (rst)
        external_timebase_select && ref_rise |=> count_tick)
        else $error("reference edge not forwarded");
    a_cnt_restart: assert property ( // [RQ14]
        @(posedge clk) disable iff (rst)
        scl_rise |=> low_cnt_r == '0)
        else $error("count not restarted on scl rise");

endmodule

/* File: verification/rbt_ctl_model.sv */
// ----------------------------------------
// bus controller model, drives scl
// ----------------------------------------
module rbt_ctl_model
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // bench commands
    input  wire logic run,
    input  wire logic stall,
    // open-drain pulls, high pulls low
    output logic      scl_pull,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    int unsigned ph;

    // 400 khz, holds scl low while stall is set
    // scl stands high outside frames; stall only when the bench asks
    always @(negedge clk)
    begin
        if (rst || stall || !run)
        begin
            ph       <= 0;
            scl_pull <= stall && !rst;
        end
        else
        begin
            ph       <= (ph == 249) ? 0 : ph + 1;
            scl_pull <= (ph < 130);
        end
    end

    // data pattern changes each bit, released idle
    always @(negedge clk)
    begin
        if (rst || !run)
            sda_pull <= 1'b0;
        else if (ph == 0)
            sda_pull <= !sda_pull;
    end
endmodule

/* File: verification/rbt_pins_tb_top.sv */
module rbt_pins_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int S = 400;
    localparam int H = 16;

    logic              clk, rst, core_sda_pull, osc_running_in, halt_flag_clear;
    logic              external_timebase_select, xtal_tick, alarm_a, alarm_b;
    logic              square_wave, sqw_irq_mode, ref_drv, run, stall;
    logic              scl_pull, sda_pull, scl_w, sda_w, ref_w;
    logic              scl_sync, sda_sync, bus_reset, bus_stalled;
    logic              oscillator_halt_flag, count_tick, square_wave_or_alarm_irq_pin;
    rbt_pkg::rbt_pin_t sda_pin, ref_pin;
    int                err_total, tests_run, cyc, pulses, n;

    // ----------------------------------------
    // wires: pullups on scl, sda, shared pin
    // ----------------------------------------
    assign scl_w = !scl_pull;
    assign sda_w = !(sda_pull || sda_pin.oe);
    assign ref_w = external_timebase_select ? ref_drv : !ref_pin.oe;

    rbt_pins #(.STALL_CYC(S), .HALT_CYC(H)) rbt_pins_i (
        .clk(clk), .rst(rst), .scl_pin_in(scl_w), .sda_pin_in(sda_w),
        .sda_pin(sda_pin), .core_sda_pull(core_sda_pull), .scl_sync(scl_sync),
        .sda_sync(sda_sync), .bus_reset(bus_reset), .bus_stalled(bus_stalled),
        .osc_running_in(osc_running_in), .halt_flag_clear(halt_flag_clear),
        .oscillator_halt_flag(oscillator_halt_flag),
        .external_timebase_select(external_timebase_select), .xtal_tick(xtal_tick),
        .count_tick(count_tick), .refclk_in_or_alarm_irq_pin_in(ref_w),
        .refclk_in_or_alarm_irq_pin(ref_pin), .alarm_a(alarm_a),
        .square_wave(square_wave), .alarm_b(alarm_b), .sqw_irq_mode(sqw_irq_mode),
        .square_wave_or_alarm_irq_pin(square_wave_or_alarm_irq_pin));

    rbt_ctl_model rbt_ctl_model_i (.clk(clk), .rst(rst), .run(run), .stall(stall),
        .scl_pull(scl_pull), .sda_pull(sda_pull));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = !clk;
    end

    // ----------------------------------------
    // pulse counter and hang guard
    // ----------------------------------------
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (bus_reset === 1'b1)
            pulses <= pulses + 1;
        if (cyc == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_clocking();
        @(negedge clk) run <= 1'b1;
        repeat (1000) @(negedge clk);
        chk("pulses_clocking", 0, pulses);
        core_sda_pull <= 1'b1;
        repeat (2) @(negedge clk);
        chk("sda_pull_low", 32'h1, sda_pin);
        @(negedge clk);
        chk("sda_seen_low", 0, sda_sync);
        core_sda_pull <= 1'b0;
        repeat (2) @(negedge clk);
        chk("sda_release", 32'h0, sda_pin);
        run <= 1'b0;
        repeat (300) @(negedge clk);
        chk("scl_idle", 1, scl_sync);
        chk("sda_idle", 1, sda_sync);
        $display("clocking done");
    endtask

    task automatic t_stall();
        core_sda_pull <= 1'b1;
        stall <= 1'b1;
        // count from the edge where the pin is seen low
        n = 0;
        while (scl_w !== 1'b0 && n < 10)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (bus_reset !== 1'b1 && n < S + 20)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("stall_latency", 1, (n >= S) && (n <= S + 5));
        chk("scl_seen_low", 0, scl_sync);
        chk("stalled_flag", 1, bus_stalled);
        chk("sda_freed", 32'h0, sda_pin);
        repeat (S + 10) @(negedge clk);
        chk("one_pulse", 1, pulses);
        chk("sda_still_freed", 32'h0, sda_pin);
        chk("sda_line_high", 1, sda_sync);
        stall <= 1'b0;
        repeat (8) @(negedge clk);
        chk("stall_cleared", 0, bus_stalled);
        chk("sda_usable", 32'h1, sda_pin);
        core_sda_pull <= 1'b0;
        $display("stall done");
    endtask

    task automatic t_osc_off();
        int first;
        first = -1;
        @(negedge clk) osc_running_in <= 1'b0;
        stall <= 1'b1;
        for (int i = 0; i < 2 * S; i++)
        begin
            @(posedge clk);
            #1;
            if (first < 0 && oscillator_halt_flag === 1'b1)
                first = i;
        end
        chk("no_reset_osc_off", 1, pulses);
        chk("halt_delay", 1, (first >= H) && (first <= H + 5));
        @(negedge clk) stall <= 1'b0;
        osc_running_in <= 1'b1;
        repeat (4) @(negedge clk);
        chk("halt_sticky", 1, oscillator_halt_flag);
        halt_flag_clear <= 1'b1;
        @(negedge clk) halt_flag_clear <= 1'b0;
        @(negedge clk);
        chk("halt_cleared", 0, oscillator_halt_flag);
        $display("oscillator done");
    endtask

    task automatic t_pins();
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk) {sqw_irq_mode, square_wave, alarm_b} <= i[2:0];
            repeat (2) @(negedge clk);
            chk("square_pin", i[2] ? !i[0] : i[1], square_wave_or_alarm_irq_pin);
        end
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk) {external_timebase_select, alarm_a} <= i[1:0];
            repeat (2) @(negedge clk);
            chk("shared_pin", (i == 1), ref_pin);
        end
        // xtal tick counts only with crystal selected
        for (int i = 0; i < 2; i++)
        begin
            @(negedge clk) external_timebase_select <= i[0];
            repeat (2) @(negedge clk);
            xtal_tick <= 1'b1;
            @(negedge clk) xtal_tick <= 1'b0;
            chk("xtal_count", !i[0], count_tick);
        end
        n = 0;
        @(negedge clk) ref_drv <= 1'b1;
        repeat (8) @(negedge clk) n += (count_tick === 1'b1);
        chk("ref_count", 1, n);
        $display("pins done");
    endtask

    initial
    begin
        {rst, core_sda_pull, halt_flag_clear, external_timebase_select} = 4'hf;
        {xtal_tick, alarm_a, alarm_b, square_wave, sqw_irq_mode} = 5'h0;
        {core_sda_pull, external_timebase_select, ref_drv, run, stall} = 5'h0;
        {osc_running_in, cyc, pulses, err_total, tests_run} = '0;
        osc_running_in = 1'b1;
        halt_flag_clear = 1'b0;
        repeat (6) @(negedge clk);
        chk("reset_sda", 32'h0, sda_pin);
        chk("reset_square", 1, square_wave_or_alarm_irq_pin);
        chk("reset_stalled", 0, bus_stalled);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        t_clocking();
        t_stall();
        t_osc_off();
        t_pins();
        end_of_test();
    end
endmodule
